// ### pkg/evflag_pkg.sv
package evflag_pkg;
    // printed offsets are not multiples of four: they are register indexes
    localparam logic [7:0] IDX_FLAGS1 = 8'h50;
    localparam logic [7:0] IDX_GATE1 = 8'h51;
    localparam logic [7:0] IDX_FLAGS2 = 8'h52;
    localparam logic [7:0] IDX_GATE2 = 8'h53;
    localparam logic [7:0] IDX_FLAGS3 = 8'h54;
    localparam logic [7:0] IDX_GATE3 = 8'h55;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h58;
    localparam logic [7:0] IDX_IRQ_CLEAR = 8'h59;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h5a;
    localparam int ADDR_W = 12;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] GATE_RESET = 8'hff;
    localparam logic [2:0] BANKS_ZERO = 3'h0;
    // bank 1 bit positions
    localparam int B1_TICK = 7;
    localparam int B1_ALARM = 6;
    localparam int B1_HOT = 5;
    localparam int B1_HOLD_RISE = 4;
    localparam int B1_LONG_PRESS = 3;
    localparam int B1_BUTTON = 2;
    localparam int B1_BATT_HIGH = 1;
    localparam int B1_HOLD_FALL = 0;
    // bank 3 bit positions
    localparam int B3_POWERDOWN = 7;
    localparam int B3_CMP2_LOW = 6;
    localparam int B3_CMP2_HIGH = 5;
    localparam int B3_WATCHDOG = 4;
    localparam int NPINS = 6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic calendar_tick;
        logic calendar_alarm;
        logic overtemp;
        logic long_press;
        logic battery_high;
        logic powerdown_high;
        logic cmp2_low;
        logic cmp2_high;
        logic watchdog;
    } event_in_t;
endpackage

// ### rtl/evflag_banks.sv
`timescale 1ns/1ps
module evflag_banks #(
    parameter logic [7:0] BATT_GATE_BOOT = 8'h01 // ORed into the gate1 reset value, which is already all ones, so it has no effect
) (
    input wire logic mclk, // 25 MHz clock
    input wire logic reset, // full reset, async high
    input wire logic general_reset, // general reset, async high
    input wire evflag_pkg::event_in_t events, // one-cycle event pulses / levels
    input wire logic power_button_input, // button level, active high
    input wire logic hold_input, // hold input level
    input wire logic [evflag_pkg::NPINS-1:0] pin_in, // gpio input levels
    output logic irq_line_out, // interrupt to host, high active
    output logic auto_switch_on_en, // automatic switch-on allowed
    input wire logic [evflag_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [evflag_pkg::ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready // read data ready
);
    import evflag_pkg::*;

    function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
        word_index = a[9:2];
    endfunction

    function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set, input logic [7:0] clr);
        w1c = (cur & ~clr) | set; // set wins over clear
    endfunction

    logic [7:0] flags1_q, flags2_q, flags3_q;
    logic [7:0] gate1_q, gate2_q, gate3_q;
    logic [2:0] bank_en_q, bank_st_q;
    logic [NPINS-1:0] pin_q;
    logic hold_q, button_q, edges_armed_q;
    logic [7:0] set1, set2, set3;
    logic [NPINS-1:0] rise, fall;

    // write channel capture
    logic aw_have_q, w_have_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_go;
    logic [7:0] wr_idx;
    logic [7:0] wr_byte;
    logic wr_known;

    // edge history; first sample only arms the detector
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pin_q <= '0;
            hold_q <= 1'b0;
            button_q <= 1'b0;
            edges_armed_q <= 1'b0;
        end else begin
            pin_q <= pin_in;
            hold_q <= hold_input;
            button_q <= power_button_input;
            edges_armed_q <= 1'b1;
        end
    end

    always_comb begin
        rise = pin_in & ~pin_q & {NPINS{edges_armed_q}};
        fall = ~pin_in & pin_q & {NPINS{edges_armed_q}};
        set1 = '0;
        set1[B1_TICK] = events.calendar_tick;
        set1[B1_ALARM] = events.calendar_alarm;
        set1[B1_HOT] = events.overtemp;
        set1[B1_HOLD_RISE] = edges_armed_q & hold_input & ~hold_q;
        set1[B1_LONG_PRESS] = events.long_press;
        set1[B1_BUTTON] = edges_armed_q & power_button_input & ~button_q;
        set1[B1_BATT_HIGH] = events.battery_high;
        set1[B1_HOLD_FALL] = edges_armed_q & ~hold_input & hold_q;
        for (int n = 0; n < 4; n++) begin
            set2[2*n] = rise[n];
            set2[2*n+1] = fall[n];
        end
        set3[B3_POWERDOWN] = events.powerdown_high;
        set3[B3_CMP2_LOW] = events.cmp2_low;
        set3[B3_CMP2_HIGH] = events.cmp2_high;
        set3[B3_WATCHDOG] = events.watchdog;
        set3[0] = rise[4];
        set3[1] = fall[4];
        set3[2] = rise[5];
        set3[3] = fall[5];
    end

    // axi write path
    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_idx = word_index(awaddr_q);
    assign wr_byte = wstrb_q[0] ? wdata_q[7:0] : 8'h00;

    always_comb begin
        case (wr_idx)
            IDX_FLAGS1, IDX_GATE1, IDX_FLAGS2, IDX_GATE2, IDX_FLAGS3, IDX_GATE3,
            IDX_IRQ_STATUS, IDX_IRQ_CLEAR, IDX_IRQ_ENABLE: wr_known = 1'b1;
            default: wr_known = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready;
            s_axi_wready <= !w_have_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
        end
    end

    // flags live in the full reset domain
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            flags1_q <= FLAGS_RESET;
            flags2_q <= FLAGS_RESET;
            flags3_q <= FLAGS_RESET;
        end else begin
            // flags update regardless of gate
            flags1_q <= w1c(flags1_q, set1, (wr_go && wr_idx == IDX_FLAGS1) ? wr_byte : 8'h00);
            flags2_q <= w1c(flags2_q, set2, (wr_go && wr_idx == IDX_FLAGS2) ? wr_byte : 8'h00);
            flags3_q <= w1c(flags3_q, set3, (wr_go && wr_idx == IDX_FLAGS3) ? wr_byte : 8'h00);
        end
    end

    // gates live in the general reset domain; full reset also sets them to all ones
    always_ff @(posedge mclk or posedge reset or posedge general_reset) begin
        if (reset || general_reset) begin
            gate1_q <= GATE_RESET & ~BATT_GATE_BOOT | BATT_GATE_BOOT;
            gate2_q <= GATE_RESET;
            gate3_q <= GATE_RESET;
        end else if (wr_go && wstrb_q[0]) begin
            if (wr_idx == IDX_GATE1) gate1_q <= wdata_q[7:0];
            if (wr_idx == IDX_GATE2) gate2_q <= wdata_q[7:0];
            if (wr_idx == IDX_GATE3) gate3_q <= wdata_q[7:0];
        end
    end

    // per-bank summary: sticky status, w1c clear register, enable
    logic [2:0] bank_pend;
    assign bank_pend = {|(flags3_q & ~gate3_q), |(flags2_q & ~gate2_q), |(flags1_q & ~gate1_q)};

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            bank_st_q <= BANKS_ZERO;
            bank_en_q <= 3'h7;
        end else begin
            bank_st_q <= (bank_st_q & ~((wr_go && wr_idx == IDX_IRQ_CLEAR) ? wr_byte[2:0] : BANKS_ZERO))
                | bank_pend;
            if (wr_go && wstrb_q[0] && wr_idx == IDX_IRQ_ENABLE) bank_en_q <= wdata_q[2:0];
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            irq_line_out <= 1'b0;
            auto_switch_on_en <= 1'b0;
        end else begin
            irq_line_out <= |(bank_pend & bank_en_q);
            auto_switch_on_en <= ~gate1_q[B1_BATT_HIGH];
        end
    end

    // axi read path: one read at a time, answer the cycle after the arvalid/arready handshake
    logic [7:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        case (word_index(s_axi_araddr))
            IDX_FLAGS1: rd_val = flags1_q;
            IDX_GATE1: rd_val = gate1_q;
            IDX_FLAGS2: rd_val = flags2_q;
            IDX_GATE2: rd_val = gate2_q;
            IDX_FLAGS3: rd_val = flags3_q;
            IDX_GATE3: rd_val = gate3_q;
            IDX_IRQ_STATUS: rd_val = {5'h00, bank_st_q};
            IDX_IRQ_CLEAR: rd_val = 8'h00;
            IDX_IRQ_ENABLE: rd_val = {5'h00, bank_en_q};
            default: begin
                rd_val = 8'h00;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_val};
                s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // evflag_banks

// ### verification/evflag_properties.sv
`timescale 1ns/1ps
module evflag_chk import evflag_pkg::*; (
    input wire logic mclk,
    input wire logic reset,
    input wire logic general_reset,
    input wire logic irq_line_out,
    input wire logic auto_switch_on_en,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    property p_aw; s_axi_awready |=> !s_axi_awready; endproperty
    a_aw: assert property (p_aw) else $error("awready held");
    property p_w; s_axi_wready |=> !s_axi_wready; endproperty
    a_w: assert property (p_w) else $error("wready held");
    property p_b; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_b: assert property (p_b) else $error("bvalid dropped");
    property p_r; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r: assert property (p_r) else $error("read answer dropped");
    property p_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_ans: assert property (p_ans) else $error("read answer late");
    // unmapped index 0x40 sits at byte 0x100
    property p_err; s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h100 |=>
        s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("unmapped read accepted");
    property p_rst; $fell(reset) |-> !irq_line_out && !s_axi_bvalid && !s_axi_rvalid; endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    property p_gen; general_reset [*2] |=> !irq_line_out && !auto_switch_on_en; endproperty
    a_gen: assert property (p_gen) else $error("gates not masked by general reset");
    // flags are sticky: only a write or the gate reset can drop the line
    property p_stick; $fell(irq_line_out) |-> s_axi_bvalid || $past(s_axi_bvalid) || general_reset
        || $past(general_reset); endproperty
    a_stick: assert property (p_stick) else $error("interrupt dropped by itself");
    c_irq: cover property ($rose(irq_line_out));
    c_err: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h100);
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule // evflag_chk
bind evflag_banks evflag_chk u_chk(.mclk, .reset, .general_reset, .irq_line_out, .auto_switch_on_en,
    .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ### verification/irq_host.sv
`timescale 1ns/1ps
module irq_host (
    input wire logic mclk,
    input wire logic irq_line_out,
    output int n_irq
);
    logic seen_q = 1'h0;
    initial n_irq = 0;
    // level line: a request counts once until it is released
    always @(posedge mclk) begin
        if (irq_line_out === 1'h1 && !seen_q) n_irq++;
        seen_q <= irq_line_out === 1'h1;
    end
endmodule // irq_host

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
    import evflag_pkg::*;
    logic mclk = 1'h0, reset = 1'h1, general_reset = 1'h0, power_button_input = 1'h0, hold_input = 1'h0;
    event_in_t events = '0;
    logic [NPINS-1:0] pin_in = '0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic irq_line_out, auto_switch_on_en, awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = '0, rdata;
    logic [1:0] bresp, rresp;
    int failures = 0, n_tests = 0, n_irq;
    logic [7:0] fl[3], gt[3];
    int evb[9] = '{B3_WATCHDOG, B3_CMP2_HIGH, B3_CMP2_LOW, B3_POWERDOWN, B1_BATT_HIGH, B1_LONG_PRESS, B1_HOT,
        B1_ALARM, B1_TICK};
    always #20 mclk = ~mclk;
    evflag_banks u_dut(.mclk, .reset, .general_reset, .events, .power_button_input, .hold_input, .pin_in,
        .irq_line_out, .auto_switch_on_en, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    irq_host u_host(.mclk, .irq_line_out, .n_irq);
    task automatic test_done;
        if (failures == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // tasks enter just after an edge and leave one edge after release
    task automatic wr(input logic [7:0] i, input logic [7:0] d, output logic [1:0] r);
        awaddr <= {2'h0, i, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'h0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
        araddr <= {2'h0, i, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        @(posedge mclk);
    endtask
    task automatic chkrd(input logic [7:0] i, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(i, d, r);
        chk({22'h0, r, d[7:0]}, {22'h0, RESP_OKAY, e});
    endtask
    function automatic logic irq_exp();
        return |((fl[0] & ~gt[0]) | (fl[1] & ~gt[1]) | (fl[2] & ~gt[2]));
    endfunction
    task automatic ckirq;
        repeat (2) @(posedge mclk);
        chk(32'(irq_line_out), 32'(irq_exp()));
    endtask
    initial begin
        logic [31:0] v, d;
        logic [1:0] r;
        v = $urandom(32'h71c0);
        fl = '{default: 8'h00};
        gt = '{default: 8'hff};
        repeat (5) @(posedge mclk);
        reset <= 1'h0;
        repeat (3) @(posedge mclk);
        for (int b = 0; b < 3; b++) begin
            chkrd(IDX_FLAGS1 + 8'(2 * b), fl[b]);
            chkrd(IDX_GATE1 + 8'(2 * b), gt[b]);
        end
        wr(8'h40, 8'hff, r);
        chk({r, 30'h0}, {RESP_SLVERR, 30'h0});
        rd(8'h40, d, r);
        chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
        repeat (24) begin
            v = $urandom;
            events <= event_in_t'(v[8:0]);
            pin_in <= v[14:9];
            power_button_input <= v[15];
            hold_input <= v[16];
            for (int i = 0; i < 9; i++) if (v[i]) fl[i < 4 ? 2 : 0][evb[i]] = 1'h1;
            if (v[15] && !power_button_input) fl[0][B1_BUTTON] = 1'h1;
            if (v[16] && !hold_input) fl[0][B1_HOLD_RISE] = 1'h1;
            if (!v[16] && hold_input) fl[0][B1_HOLD_FALL] = 1'h1;
            for (int n = 0; n < NPINS; n++) begin
                if (v[9 + n] != pin_in[n] && n < 4) fl[1][2 * n + (v[9 + n] ? 0 : 1)] = 1'h1;
                if (v[9 + n] != pin_in[n] && n > 3) fl[2][2 * n - 8 + (v[9 + n] ? 0 : 1)] = 1'h1;
            end
            @(posedge mclk);
            events <= '0;
            repeat (2) @(posedge mclk);
            for (int b = 0; b < 3; b++) chkrd(IDX_FLAGS1 + 8'(2 * b), fl[b]);
            for (int b = 0; b < 3; b++) begin
                v = $urandom;
                wr(IDX_GATE1 + 8'(2 * b), v[7:0], r);
                gt[b] = v[7:0];
                chkrd(IDX_GATE1 + 8'(2 * b), gt[b]);
            end
            ckirq;
            chk(32'(auto_switch_on_en), 32'(!gt[0][1]));
            for (int b = 0; b < 3; b++) begin
                v = $urandom;
                wr(IDX_FLAGS1 + 8'(2 * b), v[7:0], r);
                fl[b] &= ~v[7:0];
                chkrd(IDX_FLAGS1 + 8'(2 * b), fl[b]);
            end
            ckirq;
        end
        general_reset <= 1'h1;
        repeat (3) @(posedge mclk);
        general_reset <= 1'h0;
        gt = '{default: 8'hff};
        @(posedge mclk);
        for (int b = 0; b < 3; b++) chkrd(IDX_FLAGS1 + 8'(2 * b), fl[b]);
        for (int b = 0; b < 3; b++) chkrd(IDX_GATE1 + 8'(2 * b), gt[b]);
        chk(32'(n_irq > 0), 32'h1);
        wr(IDX_IRQ_CLEAR, 8'h07, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        chkrd(IDX_IRQ_STATUS, 8'h00);
        chkrd(IDX_IRQ_ENABLE, 8'h07);
        test_done;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        test_done;
    end
endmodule // tb
